// [src/bpr_top.v]
/*
  serial side of a sleeping pressure/temperature sensor: three-wire
  half-duplex serial slave taking a measurement request and a result
  read, a conversion sequencer, and result storage.
  assumes sclk, csel_b, sdio and the mode strap come from pins; the
  converter supplies compensated words when conv_done pulses.
*/
`timescale 1ns/10ps
`include "bpr_regs.vh"
module bpr_top #(
  parameter CONV_CYCLES = `BPR_CONV_CYCLES
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        sclk,
  input  wire        csel_b,
  input  wire        sdio_in,
  output reg         sdio_out,
  output reg         sdio_oe,
  output reg         two_wire_mode,
  output reg         awake,
  output reg         conv_press_start,
  output reg         conv_temp_start,
  input  wire        conv_done,
  input  wire [23:0] conv_data,
  output reg  [23:0] press_word,
  output reg  [15:0] temp_word
);
  localparam S_SLEEP = 2'd0;
  localparam S_PRESS = 2'd1;
  localparam S_TEMP  = 2'd2;
  localparam S_WAIT  = 2'd3;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [2:0] pin_q;
  bpr_sync #(.W(3), .RST(3'b010)) u_sync (
    .clk   (ref_clk),
    .rst_b (rst_b),
    .d     ({sclk, csel_b, sdio_in}),
    .q     (pin_q)
  );
  wire sclk_s = pin_q[2];
  wire csb_s  = pin_q[1];
  wire sdi_s  = pin_q[0];

  // ----------------------------------------------------------------
  // strap and edge detect
  // ----------------------------------------------------------------
  reg [1:0] strap_cnt_r;
  reg       sclk_d_r;
  reg       csb_d_r;
  wire      sclk_rise = sclk_s & ~sclk_d_r;
  wire      sclk_fall = ~sclk_s & sclk_d_r;
  wire      spi_on    = ~two_wire_mode & ~csb_s;

  function is_meas_code;
    input [7:0] b;
    begin
      is_meas_code = (b == `BPR_CMD_MEAS_A) || (b == `BPR_CMD_MEAS_B);
    end
  endfunction

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  reg [2:0]  bit_cnt_r;
  reg [7:0]  shin_r;
  reg [1:0]  byte_cnt_r;
  reg [7:0]  b0_r;
  reg [7:0]  b1_r;
  reg [7:0]  shout_r;
  reg        tx_r;
  reg        req_r;
  reg [39:0] snap_r;
  wire [7:0] byte_in = {shin_r[6:0], sdi_s};

  function [7:0] pick_byte;
    input [7:0]  addr;
    input [39:0] s;
    begin
      case (addr)
        `BPR_ADDR_P_HI:  pick_byte = s[39:32];
        `BPR_ADDR_P_MID: pick_byte = s[31:24];
        `BPR_ADDR_P_LO:  pick_byte = s[23:16];
        `BPR_ADDR_T_HI:  pick_byte = s[15:8];
        `BPR_ADDR_T_LO:  pick_byte = s[7:0];
        default:         pick_byte = 8'h00;
      endcase
    end
  endfunction

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_cnt_r   <= 2'd0;
      two_wire_mode <= 1'b1;
      sclk_d_r      <= 1'b0;
      csb_d_r       <= 1'b1;
      bit_cnt_r     <= 3'd0;
      shin_r        <= 8'h00;
      byte_cnt_r    <= 2'd0;
      b0_r          <= 8'h00;
      b1_r          <= 8'h00;
      shout_r       <= 8'h00;
      tx_r          <= 1'b0;
      req_r         <= 1'b0;
      snap_r        <= 40'h0000000000;
      sdio_out      <= 1'b0;
      sdio_oe       <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      csb_d_r  <= csb_s;
      req_r    <= 1'b0;
      // synchroniser shows its reset value for two edges after release
      if (strap_cnt_r != 2'd3)
        strap_cnt_r <= strap_cnt_r + 2'd1;
      if (strap_cnt_r == 2'd2)
        two_wire_mode <= csb_s;
      // packet snapshot at frame start, big-endian order
      if (csb_d_r & ~csb_s)
      begin
        snap_r     <= {press_word, temp_word};
        bit_cnt_r  <= 3'd0;
        byte_cnt_r <= 2'd0;
        tx_r       <= 1'b0;
      end
      if (!spi_on)
      begin
        sdio_oe  <= 1'b0;
        sdio_out <= 1'b0;
        tx_r     <= 1'b0;
      end
      else
      begin
        if (sclk_rise && !tx_r)
        begin
          shin_r    <= byte_in;
          bit_cnt_r <= bit_cnt_r + 3'd1;
          if (bit_cnt_r == 3'd7)
          begin
            byte_cnt_r <= (byte_cnt_r == 2'd2) ? 2'd0 : byte_cnt_r + 2'd1;
            if (byte_cnt_r == 2'd0)
              b0_r <= byte_in;
            else if (byte_cnt_r == 2'd1)
            begin
              b1_r <= byte_in;
              if (b0_r == `BPR_CMD_READ)
              begin
                tx_r       <= 1'b1;
                shout_r    <= pick_byte(byte_in, snap_r);
                byte_cnt_r <= 2'd2;
              end
            end
            else if (b0_r == `BPR_CMD_LEAD && is_meas_code(b1_r)
                     && byte_in == `BPR_CMD_TAIL)
              req_r <= 1'b1;
          end
        end
        else if (sclk_rise && tx_r)
        begin
          bit_cnt_r <= bit_cnt_r + 3'd1;
          if (bit_cnt_r == 3'd7)
          begin
            tx_r       <= 1'b0;
            byte_cnt_r <= 2'd0;
          end
        end
        if (sclk_fall && tx_r)
        begin
          sdio_oe  <= 1'b1;
          sdio_out <= shout_r[7];
          shout_r  <= {shout_r[6:0], 1'b0};
        end
        else if (!tx_r)
          sdio_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  reg [1:0]  state_r;
  reg [31:0] wait_r;
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r          <= S_SLEEP;
      wait_r           <= 32'd0;
      awake            <= 1'b0;
      conv_press_start <= 1'b0;
      conv_temp_start  <= 1'b0;
      press_word       <= `BPR_PRESS_RST;
      temp_word        <= `BPR_TEMP_RST;
    end
    else
    begin
      conv_press_start <= 1'b0;
      conv_temp_start  <= 1'b0;
      if (wait_r != 32'd0)
        wait_r <= wait_r - 32'd1;
      case (state_r)
        S_SLEEP:
          if (req_r)
          begin
            state_r          <= S_PRESS;
            awake            <= 1'b1;
            conv_press_start <= 1'b1;
            wait_r           <= CONV_CYCLES;
          end
        S_PRESS:
          if (conv_done)
          begin
            press_word      <= conv_data;
            conv_temp_start <= 1'b1;
            state_r         <= S_TEMP;
          end
        S_TEMP:
          if (conv_done)
          begin
            temp_word <= conv_data[15:0];
            state_r   <= S_WAIT;
          end
        S_WAIT:
          begin
            awake   <= 1'b0;
            state_r <= S_SLEEP;
          end
        default:
          state_r <= S_SLEEP;
      endcase
    end
  end
endmodule // bpr_top

// [src/bpr_regs.vh]
/*
  constants for the barometer serial readout block: command codes,
  result layout and conversion timing.
  assumes inclusion by bare name from the design files.
*/
`ifndef BPR_REGS_VH
`define BPR_REGS_VH
`define BPR_CMD_LEAD        8'h00
`define BPR_CMD_MEAS_A      8'h03
`define BPR_CMD_MEAS_B      8'h30
`define BPR_CMD_TAIL        8'h0A
`define BPR_CMD_READ        8'h80
`define BPR_ADDR_P_HI       8'h06
`define BPR_ADDR_P_MID      8'h07
`define BPR_ADDR_P_LO       8'h08
`define BPR_ADDR_T_HI       8'h09
`define BPR_ADDR_T_LO       8'h0A
`define BPR_PRESS_W         24
`define BPR_TEMP_W          16
`define BPR_PRESS_RST       24'h000000
`define BPR_TEMP_RST        16'h0000
`define BPR_CONV_TIME_US    5000
`define BPR_CLK_MHZ         200
`define BPR_CONV_CYCLES     (`BPR_CONV_TIME_US * `BPR_CLK_MHZ)
`endif

// [src/bpr_sync.v]
/*
  two flip-flop synchroniser for a bundle of pin inputs.
  assumes the inputs are asynchronous to clk; reset value parameterised.
*/
`timescale 1ns/10ps
module bpr_sync #(
  parameter W   = 3,
  parameter RST = 3'b000
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= RST;
      sync_r <= RST;
    end
    else
    begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end
  assign q = sync_r;
endmodule // bpr_sync

// [bench/bpr_chk_assertions.sv]
/* checker on the pins of bpr_top.
   assumes one clock, reset async and active low. */
`timescale 1ns/10ps
module bpr_chk #(
  parameter CONV_CYCLES = 1000000
) (
  input wire        ref_clk,
  input wire        rst_b,
  input wire        sclk,
  input wire        csel_b,
  input wire        sdio_out,
  input wire        sdio_oe,
  input wire        two_wire_mode,
  input wire        awake,
  input wire        conv_press_start,
  input wire        conv_done,
  input wire        conv_temp_start,
  input wire [23:0] press_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_clk_hi;
    sclk[*3];
  endsequence
  sequence s_done_late;
    $past(conv_done) || $past(conv_done, 2);
  endsequence
  a_press_pulse: assert property
    (conv_press_start |=> !conv_press_start) else $error("long pulse");
  a_wake_start: assert property
    (conv_press_start |-> ##[0:1] awake) else $error("no wake");
  a_temp_cause: assert property
    (conv_temp_start |-> awake ##0 s_done_late) else $error("early temp");
  a_sleep_done: assert property
    ($fell(awake) |-> s_done_late) else $error("early sleep");
  a_hold_asleep: assert property
    (!awake |=> $stable(press_word)) else $error("word moved");
  a_twowire_oe: assert property
    (two_wire_mode |-> !sdio_oe) else $error("drive in two-wire");
  a_oe_select: assert property
    (csel_b [*4] |-> !sdio_oe) else $error("drive unselected");
  a_out_falls: assert property
    (s_clk_hi ##0 (sdio_oe && $past(sdio_oe)) |-> $stable(sdio_out))
    else $error("out moved while clock high");
endmodule // bpr_chk
bind bpr_top bpr_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .csel_b(csel_b),
  .sdio_out(sdio_out), .sdio_oe(sdio_oe), .two_wire_mode(two_wire_mode),
  .awake(awake), .conv_press_start(conv_press_start),
  .conv_done(conv_done), .conv_temp_start(conv_temp_start),
  .press_word(press_word));

// [bench/bpr_host.sv]
/* serial master model driving three-byte frames.
   assumes clk is the system clock; tb calls frame and strap. */
`timescale 1ns/10ps
module bpr_host (
  input  wire clk,
  input  wire sdio_out,
  input  wire sdio_oe,
  output reg  sclk,
  output reg  csel_b,
  output wire sdio_pin
);
  reg d_r = 1'b0;
  reg drv = 1'b0;
  reg t_r = 1'b0;
  // released line wanders so a stale level never reads back
  always @(posedge clk) t_r <= ~t_r;
  assign sdio_pin = sdio_oe ? sdio_out : (drv ? d_r : t_r);
  initial sclk = 1'b0;
  initial csel_b = 1'b1;
  task strap(input v);
    csel_b = v;
  endtask
  task xfer(input [7:0] tx, input dr, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
    begin
      @(negedge clk);
      drv = dr;
      d_r = tx[i];
      repeat (5) @(negedge clk);
      rx[i] = sdio_pin;
      sclk = 1'b1;
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
  task frame(input [7:0] b0, b1, b2, input dr, output [7:0] rx);
    reg [7:0] x;
    begin
      csel_b = 1'b0;
      repeat (4) @(negedge clk);
      xfer(b0, 1'b1, x);
      xfer(b1, 1'b1, x);
      xfer(b2, dr, rx);
      repeat (4) @(negedge clk);
      csel_b = 1'b1;
      drv = 1'b0;
      repeat (10) @(negedge clk);
    end
  endtask
endmodule // bpr_host

// [bench/tb.sv]
/* self-checking bench: requests, conversions and result reads.
   assumes host model and converter model answer as the pins ask. */
`timescale 1ns/10ps
module tb;
  reg         ref_clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         conv_done = 1'b0;
  reg  [23:0] conv_data = 24'h000000;
  wire        sclk, csel_b, sdio_pin, sdio_out, sdio_oe;
  wire        two_wire_mode, awake, cps, cts;
  wire [23:0] press_word;
  wire [15:0] temp_word;
  integer     n_mismatch = 0;
  integer     cmp_count = 0;
  integer     i, k;
  reg  [31:0] seed = 32611;
  reg  [23:0] exp_p;
  reg  [15:0] exp_t;
  reg  [7:0]  rx;
  reg  [7:0]  q[$];
  always #2.5 ref_clk = ~ref_clk;
  bpr_top #(.CONV_CYCLES(200)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .sclk(sclk), .csel_b(csel_b), .sdio_in(sdio_pin), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .two_wire_mode(two_wire_mode), .awake(awake),
    .conv_press_start(cps), .conv_temp_start(cts), .conv_done(conv_done),
    .conv_data(conv_data), .press_word(press_word), .temp_word(temp_word));
  bpr_host h (.clk(ref_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sclk(sclk), .csel_b(csel_b), .sdio_pin(sdio_pin));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input [23:0] seen, input [23:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task do_reset(input v);
    @(negedge ref_clk);
    rst_b = 1'b0;
    h.strap(v);
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (6) @(negedge ref_clk);
    h.strap(1'b1);
    repeat (4) @(negedge ref_clk);
  endtask
  // converter model: random words after each start pulse
  initial forever
  begin
    @(negedge ref_clk);
    conv_done = 1'b0;
    if (cps || cts)
    begin
      seed = lfsr(seed);
      conv_data = seed[23:0];
      if (cps) exp_p = seed[23:0];
      else exp_t = seed[15:0];
      repeat (20) @(negedge ref_clk);
      conv_done = 1'b1;
    end
  end
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  initial
  begin
    do_reset(1'b1);
    chk(two_wire_mode, 1);
    h.frame(8'h00, 8'h03, 8'h0A, 1'b1, rx);
    chk(awake, 0);
    h.frame(8'h80, 8'h06, 8'h00, 1'b0, rx);
    do_reset(1'b0);
    chk(two_wire_mode, 0);
    for (k = 0; k < 3; k = k + 1)
    begin
      h.frame(8'h00, k == 0 ? 8'h03 : k == 1 ? 8'h30 : 8'h55, 8'h0A,
              1'b1, rx);
      for (i = 0; i < 300 && awake; i = i + 1) @(negedge ref_clk);
      chk(awake, 0);
      chk(press_word, exp_p);
      chk(temp_word, exp_t);
      q = {exp_p[23:16], exp_p[15:8], exp_p[7:0], exp_t[15:8], exp_t[7:0],
           8'h00};
      for (i = 0; i < 6; i = i + 1)
      begin
        h.frame(8'h80, i < 5 ? 8'h06 + i : 8'h05, 8'h00, 1'b0, rx);
        chk(rx, q.pop_front());
      end
      repeat (300) @(negedge ref_clk);
    end
    close_out;
  end
endmodule // tb
